// >>> osscfg_sequencer.sv
// optical sample sequencer: config registers, exposure sequencing, averaging
`timescale 1ns/1ns
module osscfg_sequencer #(
  parameter int unsigned CLK_FREQ_HZ = 10000000,
  parameter int unsigned ADC_WIDTH   = 19
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic      [7:0]           o_reg_rdata,
  input  wire logic                 i_acq_enable,
  input  wire logic [2:0]           i_item_count,
  input  wire logic                 i_presence_arm,
  input  wire logic                 i_adc_valid,
  input  wire logic [ADC_WIDTH-1:0] i_adc_data,
  output logic                      o_led_on,
  output logic                      o_integrate,
  output logic                      o_convert_req,
  output logic      [1:0]           o_led_item,
  output logic      [7:0]           o_led_one_drive,
  output logic      [1:0]           o_adc_range,
  output logic      [4:0]           o_adc_resolution,
  output logic                      o_dual_pulse,
  output logic                      o_powerdown,
  output logic                      o_fifo_valid,
  output logic      [1:0]           o_fifo_item,
  output logic      [ADC_WIDTH-1:0] o_fifo_data,
  output logic                      o_presence_mode,
  output logic                      o_presence_event,
  output logic                      o_soft_reset_busy
);
  localparam int ACC_W = ADC_WIDTH + 6;
  localparam int unsigned NS_PER_S = 1000000000;

  function automatic int unsigned cyc_up(input longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_FREQ_HZ + NS_PER_S - 1) / NS_PER_S;
    return (c < 1) ? 1 : int'(c);
  endfunction

  localparam int RESET_SEQ_CYC = cyc_up(osscfg_pkg::RESET_SEQ_NS);
  localparam int unsigned GAP_CYC = cyc_up(osscfg_pkg::DUAL_GAP_NS);

  if (CLK_FREQ_HZ < 1000000 || ADC_WIDTH < 8 || ADC_WIDTH > 24 || RESET_SEQ_CYC > 255)
  begin : g_chk
    $error("osscfg_sequencer: unsupported parameter values");
  end

  // per-code timing tables from the clock rate; settle and integration round up, periods round down
  logic [31:0] settle_tab [4];
  logic [31:0] tint_tab [4];
  logic [31:0] period_tab [16];
  for (genvar g = 0; g < 4; g++) begin : g_t4
    assign settle_tab[g] = 32'(cyc_up(osscfg_pkg::SETTLE_NS[g]));
    assign tint_tab[g]   = 32'(cyc_up(osscfg_pkg::TINT_NS[g]));
  end
  for (genvar g = 0; g < 16; g++) begin : g_t16
    // a period rounds down so the rate is never below the code's figure
    assign period_tab[g] = 32'(CLK_FREQ_HZ / osscfg_pkg::SAMPLE_SPS[g]);
  end

  // highest rate code for a setting; items 0 treated as one
  function automatic logic [3:0] max_rate(input logic [1:0] tint, input logic [2:0] items,
                                          input logic lp, input logic dual);
    logic hi;
    hi = tint[1];
    if (!dual) begin
      unique case (items)
        3'h2:    max_rate = hi ? ((tint[0]) ? osscfg_pkg::RC_S400 : osscfg_pkg::RC_S800)
                               : ((tint[0]) ? osscfg_pkg::RC_S800 : osscfg_pkg::RC_S1600);
        3'h3:    max_rate = hi ? ((tint[0]) ? osscfg_pkg::RC_S200 : osscfg_pkg::RC_S400)
                               : ((tint[0]) ? osscfg_pkg::RC_S800 : osscfg_pkg::RC_S1000);
        3'h4:    max_rate = hi ? ((tint[0]) ? osscfg_pkg::RC_S200 : osscfg_pkg::RC_S400)
                               : ((tint[0]) ? osscfg_pkg::RC_S400 : osscfg_pkg::RC_S1000);
        default: max_rate = hi ? ((tint[0]) ? osscfg_pkg::RC_S1000 : osscfg_pkg::RC_S1600)
                               : ((tint[0]) ? osscfg_pkg::RC_S1600 : osscfg_pkg::RC_S3200);
      endcase
    end else begin
      unique case (items)
        3'h2:    max_rate = lp ? osscfg_pkg::RC_D50 : (hi ? osscfg_pkg::RC_D84
                                                          : osscfg_pkg::RC_D100);
        3'h3:    max_rate = osscfg_pkg::RC_D50;
        3'h4:    max_rate = (hi || lp) ? osscfg_pkg::RC_D25 : osscfg_pkg::RC_D50;
        default: max_rate = osscfg_pkg::RC_D100;
      endcase
    end
  endfunction

  function automatic logic [3:0] clamp_rate(input logic [3:0] code, input logic [1:0] tint,
                                            input logic [2:0] items, input logic lp);
    logic [3:0] m;
    m = max_rate(tint, items, lp, code >= osscfg_pkg::RC_FIRST_DUAL);
    return (code > m) ? m : code;
  endfunction

  logic       busy;
  logic [7:0] rst_cnt;
  logic [1:0] range_sel;
  logic [3:0] rate_code;
  logic [1:0] tint_sel;
  logic [1:0] settle_sel;
  logic [2:0] avg_code;
  logic [7:0] thresh;
  logic [7:0] led_amp;
  logic       dynamic_powerdown_enable;
  logic       wr_ok;
  logic       presence;
  logic       hit;
  logic [3:0] next_rate;

  assign wr_ok = i_reg_wr && !busy;
  assign o_soft_reset_busy = busy;

  // soft reset sequence; writes are ignored until it completes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy    <= 1'b0;
      rst_cnt <= 8'h00;
    end else if (busy) begin
      busy    <= (rst_cnt != 8'h01);
      rst_cnt <= rst_cnt - 8'h01;
    end else if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_SYS_CTRL
                 && i_reg_wdata[osscfg_pkg::SYS_RESET_BIT]) begin
      busy    <= 1'b1;
      rst_cnt <= 8'(RESET_SEQ_CYC);
    end
  end

  always_comb begin
    next_rate = rate_code;
    if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_CFG_A) begin
      next_rate = i_reg_wdata[osscfg_pkg::CFG_A_RATE +: 4];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {range_sel, rate_code, tint_sel} <= osscfg_pkg::RST_CFG_A;
      {settle_sel, avg_code} <= osscfg_pkg::RST_CFG_B[4:0];
      thresh  <= osscfg_pkg::RST_THRESH;
      led_amp <= osscfg_pkg::RST_LED_AMP;
      dynamic_powerdown_enable <= 1'b0;
    end else if (busy) begin
      {range_sel, rate_code, tint_sel} <= osscfg_pkg::RST_CFG_A;
      {settle_sel, avg_code} <= osscfg_pkg::RST_CFG_B[4:0];
      thresh  <= osscfg_pkg::RST_THRESH;
      led_amp <= osscfg_pkg::RST_LED_AMP;
      dynamic_powerdown_enable <= 1'b0;
    end else begin
      if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_CFG_A) begin
        range_sel <= i_reg_wdata[osscfg_pkg::CFG_A_RANGE +: 2];
        tint_sel  <= i_reg_wdata[osscfg_pkg::CFG_A_TINT +: 2];
      end
      if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_CFG_B) begin
        settle_sel <= i_reg_wdata[osscfg_pkg::CFG_B_SETTLE +: 2];
        avg_code   <= i_reg_wdata[osscfg_pkg::CFG_B_AVG +: 3];
      end
      if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_THRESH) begin
        thresh <= i_reg_wdata;
      end
      if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_LED_AMP) begin
        led_amp <= i_reg_wdata;
      end
      if (wr_ok && i_reg_addr == osscfg_pkg::ADDR_SYS_CTRL) begin
        dynamic_powerdown_enable <= i_reg_wdata[osscfg_pkg::SYS_LP_BIT];
      end
      // clamped every cycle, so item count or mode changes also correct it
      rate_code <= clamp_rate(next_rate,
                              (wr_ok && i_reg_addr == osscfg_pkg::ADDR_CFG_A)
                                ? i_reg_wdata[osscfg_pkg::CFG_A_TINT +: 2] : tint_sel,
                              i_item_count, dynamic_powerdown_enable);
    end
  end

  // readback shows the substituted rate
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        osscfg_pkg::ADDR_SYS_CTRL: o_reg_rdata <= 8'((8'(dynamic_powerdown_enable) << osscfg_pkg::SYS_LP_BIT)
                                                   | 8'(busy));
        osscfg_pkg::ADDR_CFG_A:    o_reg_rdata <= {range_sel, rate_code, tint_sel};
        osscfg_pkg::ADDR_CFG_B:    o_reg_rdata <= {3'h0, settle_sel, avg_code};
        osscfg_pkg::ADDR_THRESH:   o_reg_rdata <= thresh;
        osscfg_pkg::ADDR_LED_AMP:  o_reg_rdata <= led_amp;
        default:                   o_reg_rdata <= 8'h00;
      endcase
    end
  end

  osscfg_pkg::osscfg_state_t state;
  logic [31:0] phase_cnt;
  logic [31:0] period_cnt;
  logic [1:0]  item;
  logic        pulse;
  logic [1:0]  act_tint;
  logic [1:0]  act_settle;
  logic [3:0]  act_rate;
  logic [1:0]  act_range;
  logic [1:0]  last_item;
  logic        act_lp;
  logic [2:0]  avg_log;
  logic [5:0]  smp_cnt;
  logic        dual;
  logic        conv_done;
  logic        win_last;

  assign dual      = act_rate >= osscfg_pkg::RC_FIRST_DUAL;
  assign conv_done = state == osscfg_pkg::ST_CONVERT && i_adc_valid;
  assign win_last  = smp_cnt == 6'((7'h01 << avg_log) - 7'h01);

  // settings latch only when a sample starts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state     <= osscfg_pkg::ST_IDLE;
      phase_cnt <= 32'h0;
      item      <= 2'h0;
      pulse     <= 1'b0;
      act_tint  <= 2'h0;
      act_settle <= 2'h0;
      act_rate  <= 4'h0;
      act_range <= 2'h0;
      last_item <= 2'h0;
      act_lp    <= 1'b0;
    end else if (busy) begin
      state <= osscfg_pkg::ST_IDLE;
    end else begin
      unique case (state)
        osscfg_pkg::ST_IDLE: if (i_acq_enable && i_item_count != 3'h0) begin
          act_tint   <= tint_sel;
          act_settle <= settle_sel;
          act_rate   <= rate_code;
          act_range  <= range_sel;
          act_lp     <= dynamic_powerdown_enable;
          last_item  <= (i_item_count > 3'h4) ? 2'h3 : 2'(i_item_count - 3'h1);
          item       <= 2'h0;
          pulse      <= 1'b0;
          phase_cnt  <= settle_tab[settle_sel] - 32'h1;
          state      <= osscfg_pkg::ST_SETTLE;
        end
        osscfg_pkg::ST_SETTLE: if (phase_cnt == 32'h0) begin
          phase_cnt <= tint_tab[act_tint] - 32'h1;
          state     <= osscfg_pkg::ST_INTEG;
        end else begin
          phase_cnt <= phase_cnt - 32'h1;
        end
        osscfg_pkg::ST_INTEG: if (phase_cnt == 32'h0) begin
          state <= osscfg_pkg::ST_CONVERT;
        end else begin
          phase_cnt <= phase_cnt - 32'h1;
        end
        osscfg_pkg::ST_CONVERT: if (i_adc_valid) begin
          if (dual && !pulse) begin
            pulse     <= 1'b1;
            phase_cnt <= GAP_CYC - 32'h1;
            state     <= osscfg_pkg::ST_GAP;
          end else if (item == last_item) begin
            state <= osscfg_pkg::ST_WAIT;
          end else begin
            item      <= item + 2'h1;
            pulse     <= 1'b0;
            phase_cnt <= settle_tab[act_settle] - 32'h1;
            state     <= osscfg_pkg::ST_SETTLE;
          end
        end
        osscfg_pkg::ST_GAP: if (phase_cnt == 32'h0) begin
          phase_cnt <= settle_tab[act_settle] - 32'h1;
          state     <= osscfg_pkg::ST_SETTLE;
        end else begin
          phase_cnt <= phase_cnt - 32'h1;
        end
        osscfg_pkg::ST_WAIT: if (period_cnt <= 32'h1) begin
          state <= osscfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // sample period runs from each sample start, independent of phases
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      period_cnt <= 32'h0;
    end else if (state == osscfg_pkg::ST_IDLE) begin
      period_cnt <= period_tab[rate_code] - 32'h1;
    end else if (period_cnt != 32'h0) begin
      period_cnt <= period_cnt - 32'h1;
    end
  end

  // averaging window; the depth latches only when a window opens
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      smp_cnt <= 6'h0;
      avg_log <= 3'h0;
    end else if (busy) begin
      smp_cnt <= 6'h0;
      avg_log <= 3'h0;
    end else begin
      if (state == osscfg_pkg::ST_IDLE && smp_cnt == 6'h0) begin
        avg_log <= (avg_code > osscfg_pkg::AVG_MAX_LOG) ? osscfg_pkg::AVG_MAX_LOG
                                                       : avg_code;
      end
      if (conv_done && item == last_item && pulse == dual) begin
        smp_cnt <= win_last ? 6'h0 : smp_cnt + 6'h1;
      end
    end
  end

  // one accumulator per item so channels never mix
  logic [ACC_W-1:0] acc [4];
  for (genvar g = 0; g < 4; g++) begin : g_acc
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        acc[g] <= '0;
      end else if (busy) begin
        acc[g] <= '0;
      end else if (conv_done && item == 2'(g)) begin
        acc[g] <= ((smp_cnt == 6'h0 && !pulse) ? '0 : acc[g])
                  + ACC_W'(i_adc_data);
      end
    end
  end

  logic [ACC_W-1:0] sum_now;
  assign sum_now = ((smp_cnt == 6'h0 && !pulse) ? '0 : acc[item]) + ACC_W'(i_adc_data);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fifo_valid <= 1'b0;
      o_fifo_item  <= 2'h0;
      o_fifo_data  <= '0;
    end else begin
      o_fifo_valid <= conv_done && !busy && win_last && pulse == dual;
      if (conv_done && win_last && pulse == dual) begin
        o_fifo_item <= item;
        o_fifo_data <= ADC_WIDTH'(sum_now >> (avg_log + 3'(dual)));
      end
    end
  end

  // presence: first item's top bits against threshold; 0xFF needs full scale
  assign hit = presence && conv_done && item == 2'h0
               && ((thresh == osscfg_pkg::THRESH_SAT) ? &i_adc_data
                   : i_adc_data[ADC_WIDTH-1 -: 8] >= thresh);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presence         <= 1'b0;
      o_presence_event <= 1'b0;
    end else if (busy) begin
      presence         <= 1'b0;
      o_presence_event <= 1'b0;
    end else begin
      presence         <= i_presence_arm || (presence && !hit);
      o_presence_event <= hit && !i_presence_arm;
    end
  end

  assign o_presence_mode  = presence;
  assign o_led_on         = state == osscfg_pkg::ST_SETTLE
                            || state == osscfg_pkg::ST_INTEG;
  assign o_integrate      = state == osscfg_pkg::ST_INTEG;
  assign o_convert_req    = state == osscfg_pkg::ST_CONVERT;
  assign o_led_item       = item;
  assign o_led_one_drive  = (o_led_on && item == 2'h0) ? led_amp : 8'h00;
  assign o_adc_range      = act_range;
  assign o_adc_resolution = osscfg_pkg::RES_BASE_BITS + 5'(act_tint);
  assign o_dual_pulse     = dual;
  // high rates keep the front end powered between samples
  assign o_powerdown      = state == osscfg_pkg::ST_WAIT && act_lp
                            && (dual || act_rate <= osscfg_pkg::RC_S100);

  logic [31:0] on_cnt;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_cnt <= 32'h0;
    end else begin
      on_cnt <= o_led_on ? on_cnt + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_soft_reset_clears: assert property ($fell(busy) |-> rate_code == 4'h0
    && thresh == osscfg_pkg::RST_THRESH && led_amp == osscfg_pkg::RST_LED_AMP)
    else $error("registers not at defaults after soft reset");
  a_reset_bit_clears: assert property ($rose(busy) |-> ##[1:RESET_SEQ_CYC] !busy)
    else $error("soft reset bit did not clear");
  a_rate_clamped: assert property (!busy |=> rate_code <= max_rate(tint_sel,
    $past(i_item_count), $past(dynamic_powerdown_enable), rate_code >= osscfg_pkg::RC_FIRST_DUAL))
    else $error("unsupported rate left in place");
  a_dual_three_cap: assert property ($past(i_item_count) == 3'h3 && !$past(busy)
    && rate_code >= osscfg_pkg::RC_FIRST_DUAL |-> rate_code <= osscfg_pkg::RC_D50)
    else $error("dual rate above cap for three items");
  a_led_window_len: assert property ($fell(o_led_on) && $past(state) == osscfg_pkg::ST_INTEG
    && !$past(busy) |-> $past(on_cnt) + 32'h1
    == settle_tab[act_settle] + tint_tab[act_tint])
    else $error("LED window not settle plus integration");
  a_settle_to_integ: assert property (state == osscfg_pkg::ST_SETTLE
    && phase_cnt == 32'h0 && !busy |=> state == osscfg_pkg::ST_INTEG)
    else $error("settle not followed by integration");
  a_settings_stable: assert property (state != osscfg_pkg::ST_IDLE
    && $past(state) != osscfg_pkg::ST_IDLE |-> $stable(act_tint) && $stable(act_rate))
    else $error("settings changed inside a sample");
  a_presence_sat: assert property (o_presence_event && thresh == osscfg_pkg::THRESH_SAT
    |-> &$past(i_adc_data))
    else $error("presence at 0xFF without saturation");
  a_presence_exit: assert property (o_presence_event |-> !presence && $past(item) == 2'h0)
    else $error("presence event without leaving presence mode");
  a_powerdown_rate: assert property (o_powerdown |-> act_rate <= osscfg_pkg::RC_S100
    || act_rate >= osscfg_pkg::RC_FIRST_DUAL)
    else $error("power-down at a rate above 100sps");
  a_fifo_item: assert property (o_fifo_valid |-> o_fifo_item == $past(item)
    && $past(state) == osscfg_pkg::ST_CONVERT)
    else $error("averaged result tagged with wrong item");
endmodule

// >>> osscfg_pkg.sv
// constants and types for the optical sample sequencer configuration block
package osscfg_pkg;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_CFG_A    = 8'h0E;
  localparam logic [7:0] ADDR_CFG_B    = 8'h0F;
  localparam logic [7:0] ADDR_THRESH   = 8'h10;
  localparam logic [7:0] ADDR_LED_AMP  = 8'h11;
  localparam logic [7:0] RST_CFG_A     = 8'h00;
  localparam logic [7:0] RST_CFG_B     = 8'h18;
  localparam logic [7:0] RST_THRESH    = 8'h00;
  localparam logic [7:0] RST_LED_AMP   = 8'h00;
  localparam int SYS_RESET_BIT = 0;
  localparam int SYS_LP_BIT    = 3;
  localparam int CFG_A_RANGE   = 6;
  localparam int CFG_A_RATE    = 2;
  localparam int CFG_A_TINT    = 0;
  localparam int CFG_B_SETTLE  = 3;
  localparam int CFG_B_AVG     = 0;
  localparam logic [3:0] RC_S100 = 4'h4;
  localparam logic [3:0] RC_S200 = 4'h5;
  localparam logic [3:0] RC_S400 = 4'h6;
  localparam logic [3:0] RC_S800 = 4'h7;
  localparam logic [3:0] RC_S1000 = 4'h8;
  localparam logic [3:0] RC_S1600 = 4'h9;
  localparam logic [3:0] RC_S3200 = 4'hA;
  localparam logic [3:0] RC_FIRST_DUAL = 4'hB;
  localparam logic [3:0] RC_D25  = 4'hC;
  localparam logic [3:0] RC_D50  = 4'hD;
  localparam logic [3:0] RC_D84  = 4'hE;
  localparam logic [3:0] RC_D100 = 4'hF;
  localparam logic [2:0] AVG_MAX_LOG = 3'h5;
  localparam logic [4:0] RES_BASE_BITS = 5'h10;
  localparam logic [7:0] THRESH_SAT = 8'hFF;
  localparam int unsigned SAMPLE_SPS [16] =
    '{20, 25, 50, 84, 100, 200, 400, 800, 1000, 1600, 3200, 20, 25, 50, 84, 100};
  localparam int unsigned SETTLE_NS [4] = '{2500, 5000, 10000, 20000};
  localparam int unsigned TINT_NS [4] = '{52000, 104000, 206000, 417000};
  localparam int unsigned DUAL_GAP_NS = 5000000;
  localparam int unsigned RESET_SEQ_NS = 1000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE, ST_INTEG, ST_CONVERT, ST_GAP, ST_WAIT
  } osscfg_state_t;
endpackage

// >>> osscfg_front_end.sv
// behavioural photodiode and converter front end answering conversion requests
`timescale 1ns/1ns
module osscfg_front_end #(
  parameter int DELAY = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_convert_req,
  input  wire logic [18:0] i_level,
  output logic             o_adc_valid,
  output logic      [18:0] o_adc_data
);
  int cnt;
  // off the valid cycle the bus toggles, so a stale result never matches
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_adc_valid <= 1'b0;
      o_adc_data <= 19'h7FFFF;
    end else if (i_convert_req && !o_adc_valid && cnt == DELAY) begin
      cnt <= 0;
      o_adc_valid <= 1'b1;
      o_adc_data <= i_level;
    end else begin
      cnt <= (i_convert_req && !o_adc_valid) ? cnt + 1 : 0;
      o_adc_valid <= 1'b0;
      o_adc_data <= ~o_adc_data;
    end
  end
endmodule

// >>> osscfg_sequencer_tb.sv
// self-checking bench for the sequencer configuration block
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h expected %h", $time, g, e); end end
module osscfg_sequencer_tb;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        acq = 1'b0;
  logic [2:0]  items = 3'h1;
  logic        arm = 1'b0;
  logic [18:0] level = 19'h00800;
  logic        adc_valid, led_on, conv, fifo_valid, pmode, pevent, busy, dual, integ, pdown;
  logic [18:0] adc_data, fifo_data;
  logic [1:0]  led_item, fifo_item, range;
  logic [7:0]  rdata, drive;
  logic [4:0]  res;
  int          mismatches = 0;
  int          total_checks = 0;
  int          events = 0;
  int          on;
  time         t0;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (pevent === 1'b1) events++;
  osscfg_sequencer #(.CLK_FREQ_HZ(1000000), .ADC_WIDTH(19)) dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_acq_enable(acq),
    .i_item_count(items), .i_presence_arm(arm), .i_adc_valid(adc_valid),
    .i_adc_data(adc_data), .o_led_on(led_on), .o_integrate(integ), .o_convert_req(conv),
    .o_led_item(led_item), .o_led_one_drive(drive), .o_adc_range(range),
    .o_adc_resolution(res), .o_dual_pulse(dual), .o_powerdown(pdown),
    .o_fifo_valid(fifo_valid),
    .o_fifo_item(fifo_item), .o_fifo_data(fifo_data), .o_presence_mode(pmode),
    .o_presence_event(pevent), .o_soft_reset_busy(busy));
  osscfg_front_end #(.DELAY(3)) fe (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_convert_req(conv), .i_level(level), .o_adc_valid(adc_valid), .o_adc_data(adc_data));
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #10 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge i_clk);
    #10 wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    #10 addr = a;
    rd = 1'b1;
    @(posedge i_clk);
    #10 rd = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic wait_high(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      #10 n++;
    end
    `CHK(s, 1'b1)
  endtask
  task automatic next_fifo;
    @(posedge i_clk);
    #10 wait_high(fifo_valid);
  endtask
  task automatic pulse_arm;
    @(posedge i_clk);
    #10 arm = 1'b1;
    @(posedge i_clk);
    #10 arm = 1'b0;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // about 13000 cycles of tests, limit set well beyond
  initial begin
    #4000000;
    mismatches++;
    results();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    #10 i_rst_b = 1'b1;
    rreg(8'h0E, 8'h00);
    rreg(8'h0F, 8'h18);
    rreg(8'h10, 8'h00);
    rreg(8'h11, 8'h00);
    rreg(8'h30, 8'h00);
    wreg(8'h0E, 8'hEB);
    rreg(8'h0E, 8'hE3);
    items = 3'h3;
    wreg(8'h0E, 8'h3C);
    rreg(8'h0E, 8'h34);
    items = 3'h1;
    wreg(8'h0E, 8'h3C);
    rreg(8'h0E, 8'h3C);
    // dual shows the active rate, so a sample must start; soft reset aborts it
    acq = 1'b1;
    wait_high(led_on);
    `CHK(dual, 1'b1)
    acq = 1'b0;
    wreg(8'h10, 8'h5A);
    wreg(8'h11, 8'hA5);
    wreg(8'h0D, 8'h01);
    `CHK(busy, 1'b1)
    repeat (12) @(posedge i_clk);
    #10 `CHK(busy, 1'b0)
    rreg(8'h0D, 8'h00);
    rreg(8'h0E, 8'h00);
    rreg(8'h10, 8'h00);
    rreg(8'h11, 8'h00);
    // 1000 sps, range 2, shortest integration, settle code 3, average of 2
    wreg(8'h0E, 8'hA0);
    wreg(8'h0F, 8'h19);
    rreg(8'h0F, 8'h19);
    wreg(8'h11, 8'hA5);
    wreg(8'h10, 8'h01);
    pulse_arm();
    `CHK(pmode, 1'b1)
    acq = 1'b1;
    wait_high(led_on);
    `CHK(integ, 1'b0)
    `CHK(led_item, 2'h0)
    `CHK(drive, 8'hA5)
    `CHK(range, 2'h2)
    `CHK(res, 5'h10)
    on = 1;
    while (led_on === 1'b1 && on < 1000) begin
      @(posedge i_clk);
      #10 on++;
    end
    `CHK(on, 73)
    `CHK(conv, 1'b1)
    wait_high(fifo_valid);
    t0 = $time;
    `CHK(fifo_data, 19'h00800)
    `CHK(fifo_item, 2'h0)
    `CHK(pmode, 1'b0)
    `CHK(events, 1)
    next_fifo();
    `CHK(($time - t0) / 100, 2000)
    // near-full result below saturation must not end presence mode
    wreg(8'h10, 8'hFF);
    level = 19'h7F800;
    pulse_arm();
    next_fifo();
    next_fifo();
    `CHK(events, 1)
    `CHK(pmode, 1'b1)
    level = 19'h7FFFF;
    next_fifo();
    next_fifo();
    `CHK(fifo_data, 19'h7FFFF)
    `CHK(events, 2)
    `CHK(pmode, 1'b0)
    // low power on, but 1000 sps is too fast to power down between samples
    wreg(8'h0D, 8'h08);
    rreg(8'h0D, 8'h08);
    next_fifo();
    `CHK(pdown, 1'b0)
    acq = 1'b0;
    results();
  end
endmodule
